// ### core/battery_state_alarm_params.svh
// constants for the battery state and alarm threshold block
`ifndef BATTERY_STATE_ALARM_PARAMS_SVH
`define BATTERY_STATE_ALARM_PARAMS_SVH
`define CMD_MAKER_PORT       8'h00
`define CMD_LOW_CAPACITY     8'h01
`define CMD_LOW_RUNTIME      8'h02
`define STATUS_STATE_LSB     8
`define STATUS_LOW_BYTE      8'h0A
`define SW_CFG_ZV            2'h0
`define SW_CFG_SHARED        2'h1
`define SW_CFG_PRECHG        2'h2
`define ALARM_FLAG_CAPACITY  16'h0200
`define ALARM_FLAG_RUNTIME   16'h0100
`define CFG_ADDR_RUNTIME_LO  9'h000
`define CFG_ADDR_RUNTIME_HI  9'h001
`define CFG_ADDR_CAPACITY_LO 9'h002
`define CFG_ADDR_CAPACITY_HI 9'h003
`define CFG_ADDR_DSG_DET_LO  9'h115
`define CFG_ADDR_DSG_DET_HI  9'h116
`endif

// ### core/battery_state_alarm_pkg.sv
// types for the battery state and alarm threshold block
`default_nettype none
package battery_state_alarm_pkg;
  typedef enum logic [3:0] {
    ST_WAKEUP      = 4'h0,
    ST_NORMAL      = 4'h1,
    ST_PRECHARGE   = 4'h3,
    ST_CHG_SUSPEND = 4'h4,
    ST_CHARGE      = 4'h5,
    ST_CHG_TERM    = 4'h7,
    ST_FAULT_TERM  = 4'h8,
    ST_PERM_FAIL   = 4'h9,
    ST_OVERCURRENT = 4'hA,
    ST_BATT_FAIL   = 4'hC,
    ST_SLEEP       = 4'hD,
    ST_SYS_PRESENT = 4'hE,
    ST_REMOVED     = 4'hF
  } state_code_t;
  typedef enum logic [1:0] {
    LD_RUNTIME  = 2'b00,
    LD_CAPACITY = 2'b01,
    LD_DONE     = 2'b11
  } load_state_t;
endpackage
`default_nettype wire

// ### core/battery_state_alarm_regs.sv
// battery state code, switch exceptions and alarm thresholds
//
// Overview of operation
// [RULE1] state code sits in status bits 11..8
// [RULE2] state field uses the documented state codes
// [RULE3] charge switch on above discharge detect current
// [RULE4] shared switch config turns charge switch on
// [RULE5] wake-up: zero-volt on, overdischarge off
// [RULE6] precharge/depleted-ac: config picks zero-volt or overdischarge
// [RULE7] charge state requests zero below precharge voltage
// [RULE8] fixed pack keeps failure-state switch on
// [RULE9] host writes and reads low capacity threshold
// [RULE10] capacity below threshold sends capacity alarm
// [RULE11] zero capacity threshold suppresses its alarm
// [RULE12] capacity threshold loads from config 0x02-0x03
// [RULE13] capacity threshold holds until host write
// [RULE14] capacity threshold unsigned, unit set by mode
// [RULE15] runtime below threshold sends runtime alarm
// [RULE16] zero runtime threshold suppresses its alarm
// [RULE17] runtime threshold loads from config 0x00-0x01
// [RULE18] runtime threshold holds until host write
// [RULE19] runtime threshold unsigned minutes
// [RULE20] alarms go out as master write word
// [RULE21] compare on each update, repeat while true
`include "battery_state_alarm_params.svh"
`default_nettype none
module battery_state_alarm_regs #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         I_REF_CLK,
  input  wire logic         I_RST,
  // command port: word read and write by command code
  input  wire logic         i_cmd_wr,
  input  wire logic         i_cmd_rd,
  input  wire logic [7:0]   i_cmd_code,
  input  wire logic [W-1:0] i_cmd_wdata,
  output logic [W-1:0]      o_cmd_rdata,
  // configuration memory read port
  output logic [8:0]        o_cfg_addr,
  input  wire logic [7:0]   i_cfg_data,
  output logic              o_init_done,
  // gauge state inputs
  input  wire logic [3:0]   i_state_code,
  input  wire logic         i_depleted_ac,
  input  wire logic [1:0]   i_switch_configuration,
  input  wire logic         i_fixed_pack_option,
  input  wire logic         i_capacity_unit_mode,
  input  wire logic [1:0]   i_switch_status,
  input  wire logic [1:0]   i_fail_cause,
  input  wire logic         i_fail_charge_side,
  input  wire logic [W-1:0] i_discharge_current,
  input  wire logic         i_min_cell_below_pc,
  input  wire logic [W-1:0] i_charge_current_nominal,
  input  wire logic [W-1:0] i_capacity_left,
  input  wire logic         i_capacity_update,
  input  wire logic [W-1:0] i_mean_runtime_left,
  input  wire logic         i_runtime_update,
  // switch controls
  output logic              o_charge_switch,
  output logic              o_discharge_switch,
  output logic              o_zero_volt_charge_switch,
  output logic              o_overdischarge_switch,
  output logic [W-1:0]      o_requested_charge_current,
  // alarm broadcast request, write word as bus master
  output logic              o_alarm_broadcast,
  output logic [W-1:0]      o_alarm_word,
  input  wire logic         i_alarm_done
);

  logic [W-1:0] low_capacity_threshold;
  logic [W-1:0] low_runtime_threshold;
  logic [W-1:0] dsg_detect;
  logic [7:0]   cfg_lo;
  logic [2:0]   ld_step;
  battery_state_alarm_pkg::load_state_t ld_state;
  logic         alarm_pending;
  logic [W-1:0] alarm_flags;
  logic         cap_alarm;
  logic         rt_alarm;

  function automatic logic below(input logic [W-1:0] v, input logic [W-1:0] thr);
    below = (thr != '0) && (v < thr);
  endfunction

  // init sequence reads six config bytes, low byte first
  wire [8:0] cfg_addr_tbl [0:5];
  assign cfg_addr_tbl[0] = `CFG_ADDR_RUNTIME_LO;
  assign cfg_addr_tbl[1] = `CFG_ADDR_RUNTIME_HI;
  assign cfg_addr_tbl[2] = `CFG_ADDR_CAPACITY_LO;
  assign cfg_addr_tbl[3] = `CFG_ADDR_CAPACITY_HI;
  assign cfg_addr_tbl[4] = `CFG_ADDR_DSG_DET_LO;
  assign cfg_addr_tbl[5] = `CFG_ADDR_DSG_DET_HI;
  wire   loading = (ld_state != battery_state_alarm_pkg::LD_DONE);
  wire   ld_last = (ld_step == 3'd5);
  wire [W-1:0] cfg_word = {i_cfg_data, cfg_lo};

  // config memory answers combinationally for the address shown
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      ld_step  <= 3'd0;
      cfg_lo   <= 8'h00;
      ld_state <= battery_state_alarm_pkg::LD_RUNTIME;
    end else if (loading) begin
      cfg_lo  <= i_cfg_data;
      ld_step <= ld_last ? ld_step : ld_step + 3'd1;
      case (ld_state)
        battery_state_alarm_pkg::LD_RUNTIME:
          if (ld_step == 3'd1) ld_state <= battery_state_alarm_pkg::LD_CAPACITY;
        battery_state_alarm_pkg::LD_CAPACITY:
          if (ld_last) ld_state <= battery_state_alarm_pkg::LD_DONE;
        default: ld_state <= battery_state_alarm_pkg::LD_DONE;
      endcase
    end
  end
  assign o_cfg_addr  = cfg_addr_tbl[ld_step];
  assign o_init_done = !loading;

  wire wr_cap = i_cmd_wr && !loading && (i_cmd_code == `CMD_LOW_CAPACITY);
  wire wr_rt  = i_cmd_wr && !loading && (i_cmd_code == `CMD_LOW_RUNTIME);

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      low_capacity_threshold <= 16'h0000;
      low_runtime_threshold  <= 16'h0000;
      dsg_detect             <= 16'hFFFF;
    end else begin
      if (loading && ld_step == 3'd1) low_runtime_threshold <= cfg_word;   // [RULE17]
      else if (wr_rt) low_runtime_threshold <= i_cmd_wdata;                // [RULE18]
      if (loading && ld_step == 3'd3) low_capacity_threshold <= cfg_word;  // [RULE12]
      else if (wr_cap) low_capacity_threshold <= i_cmd_wdata;              // [RULE13]
      if (loading && ld_step == 3'd5) dsg_detect <= cfg_word;
    end
  end

  // status word: switches, fail cause, state code, fixed low byte
  wire [W-1:0] status_word = {i_switch_status, i_fail_cause, i_state_code, `STATUS_LOW_BYTE}; // [RULE1] [RULE2]

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) o_cmd_rdata <= 16'h0000;
    else if (i_cmd_rd) begin
      case (i_cmd_code)
        `CMD_MAKER_PORT:   o_cmd_rdata <= status_word;
        `CMD_LOW_CAPACITY: o_cmd_rdata <= low_capacity_threshold; // [RULE9] [RULE14]
        `CMD_LOW_RUNTIME:  o_cmd_rdata <= low_runtime_threshold;  // [RULE19]
        default:           o_cmd_rdata <= 16'h0000;
      endcase
    end
  end

  // switch table per state
  wire st_wake = (i_state_code == battery_state_alarm_pkg::ST_WAKEUP);
  wire st_pre  = (i_state_code == battery_state_alarm_pkg::ST_PRECHARGE);
  wire st_chg  = (i_state_code == battery_state_alarm_pkg::ST_CHARGE);
  wire st_norm = (i_state_code == battery_state_alarm_pkg::ST_NORMAL);
  wire st_fail = (i_state_code == battery_state_alarm_pkg::ST_BATT_FAIL) ||
                 (i_state_code == battery_state_alarm_pkg::ST_OVERCURRENT);
  wire dsg_hi  = (i_discharge_current > dsg_detect);
  wire cfg_zv  = (i_switch_configuration == `SW_CFG_ZV);
  wire cfg_sh  = (i_switch_configuration == `SW_CFG_SHARED);
  wire cfg_pc  = (i_switch_configuration == `SW_CFG_PRECHG);
  wire pre_like = st_pre || (i_depleted_ac && st_norm);

  wire next_chg = dsg_hi ||                                 // [RULE3]
                  ((st_wake || st_pre) && cfg_sh) ||        // [RULE4]
                  st_chg || (st_norm && !i_depleted_ac && !i_fail_charge_side) ||
                  (st_fail && !i_fail_charge_side && i_fixed_pack_option); // [RULE8]
  wire next_dsg = st_wake || st_pre || st_norm && !i_depleted_ac ||
                  (i_state_code == battery_state_alarm_pkg::ST_CHG_SUSPEND) ||
                  (i_state_code == battery_state_alarm_pkg::ST_CHG_TERM) ||
                  (i_state_code == battery_state_alarm_pkg::ST_FAULT_TERM) || st_chg ||
                  (st_fail && i_fail_charge_side && i_fixed_pack_option);  // [RULE8]
  wire next_zv  = (st_wake && (cfg_zv || cfg_pc)) || (pre_like && cfg_zv);  // [RULE5] [RULE6]
  wire next_od  = pre_like && cfg_pc;                                       // [RULE6]
  wire [W-1:0] next_cc = (st_chg && i_min_cell_below_pc) ? 16'h0000 : i_charge_current_nominal; // [RULE7]

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      o_charge_switch            <= 1'b0;
      o_discharge_switch         <= 1'b0;
      o_zero_volt_charge_switch  <= 1'b0;
      o_overdischarge_switch     <= 1'b0;
      o_requested_charge_current <= 16'h0000;
    end else begin
      o_charge_switch            <= next_chg;
      o_discharge_switch         <= next_dsg;
      o_zero_volt_charge_switch  <= next_zv;
      o_overdischarge_switch     <= next_od;
      o_requested_charge_current <= next_cc;
    end
  end

  // alarm compare on each update; held until the next update
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      cap_alarm <= 1'b0;
      rt_alarm  <= 1'b0;
    end else begin
      if (i_capacity_update) cap_alarm <= below(i_capacity_left, low_capacity_threshold);  // [RULE10] [RULE11] [RULE21]
      if (i_runtime_update)  rt_alarm  <= below(i_mean_runtime_left, low_runtime_threshold); // [RULE15] [RULE16] [RULE21]
    end
  end

  // a new update re-arms a broadcast while the condition persists, unless a request still waits for done
  wire upd = i_capacity_update || i_runtime_update;
  wire [W-1:0] next_flags = (cap_alarm ? `ALARM_FLAG_CAPACITY : 16'h0000) |
                            (rt_alarm  ? `ALARM_FLAG_RUNTIME  : 16'h0000);
  logic upd_d;
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      upd_d         <= 1'b0;
      alarm_pending <= 1'b0;
      alarm_flags   <= 16'h0000;
    end else begin
      upd_d <= upd;
      // a re-arm in the done cycle wins over the clear
      if (upd_d && next_flags != 16'h0000 && (!alarm_pending || i_alarm_done)) begin
        alarm_pending <= 1'b1;                        // [RULE21]
        alarm_flags   <= next_flags;
      end else if (i_alarm_done) alarm_pending <= 1'b0;
    end
  end
  assign o_alarm_broadcast = alarm_pending;             // [RULE20]
  assign o_alarm_word      = alarm_flags;

  thr_hold_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (o_init_done && !wr_cap) |=> $stable(low_capacity_threshold))
    else $error("capacity threshold changed without write"); // [RULE13]
  rt_hold_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (o_init_done && !wr_rt) |=> $stable(low_runtime_threshold))
    else $error("runtime threshold changed without write"); // [RULE18]
  cap_zero_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (low_capacity_threshold == 16'h0000 && i_capacity_update) |=> !cap_alarm)
    else $error("capacity alarm with zero threshold"); // [RULE11]
  rt_zero_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (low_runtime_threshold == 16'h0000 && i_runtime_update) |=> !rt_alarm)
    else $error("runtime alarm with zero threshold"); // [RULE16]
  cap_alarm_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (i_capacity_update && low_capacity_threshold != 16'h0000 &&
     i_capacity_left < low_capacity_threshold) |=> cap_alarm)
    else $error("capacity alarm missed"); // [RULE10]
  chg_dsg_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    dsg_hi |=> o_charge_switch)
    else $error("charge switch off under discharge"); // [RULE3]
  cc_zero_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (st_chg && i_min_cell_below_pc) |=> o_requested_charge_current == 16'h0000)
    else $error("charge current not zeroed"); // [RULE7]
  wake_zv_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (st_wake && cfg_zv) |=> (o_zero_volt_charge_switch && !o_overdischarge_switch))
    else $error("wake-up zero-volt switch wrong"); // [RULE5]
  read_back_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (i_cmd_rd && i_cmd_code == `CMD_LOW_RUNTIME && !wr_rt) |=>
      o_cmd_rdata == low_runtime_threshold)
    else $error("runtime threshold read back wrong"); // [RULE19]
  state_field_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (i_cmd_rd && i_cmd_code == `CMD_MAKER_PORT) |=> o_cmd_rdata[11:8] == $past(i_state_code))
    else $error("state code misplaced"); // [RULE1]
  init_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (loading && ld_step == 3'd3) |=> low_capacity_threshold == $past(cfg_word))
    else $error("capacity threshold not loaded"); // [RULE12]
  rt_init_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // [RULE17]
    (loading && ld_step == 3'd1) |=> low_runtime_threshold == $past(cfg_word))
    else $error("runtime threshold not loaded");
  rt_alarm_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // [RULE15]
    (i_runtime_update && low_runtime_threshold != 16'h0000 &&
     i_mean_runtime_left < low_runtime_threshold) |=> rt_alarm)
    else $error("runtime alarm missed");
  cap_read_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // [RULE9]
    (o_init_done && i_cmd_rd && i_cmd_code == `CMD_LOW_CAPACITY && !wr_cap) |=>
      o_cmd_rdata == low_capacity_threshold)
    else $error("capacity threshold read back wrong");
  // unit mode only changes what the number means, never the stored word
  unit_keep_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // [RULE14]
    (o_init_done && !wr_cap && $changed(i_capacity_unit_mode)) |=> $stable(low_capacity_threshold))
    else $error("capacity threshold moved with unit mode");
  status_low_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // [RULE1]
    (i_cmd_rd && i_cmd_code == `CMD_MAKER_PORT) |=> o_cmd_rdata[7:0] == `STATUS_LOW_BYTE)
    else $error("status low byte wrong");
  shared_chg_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // [RULE4]
    ((st_wake || st_pre) && cfg_sh) |=> o_charge_switch)
    else $error("shared config charge switch off");
  pre_zv_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // [RULE6]
    (pre_like && cfg_zv) |=> (o_zero_volt_charge_switch && !o_overdischarge_switch))
    else $error("precharge zero-volt switch wrong");
  pre_od_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // [RULE6]
    (pre_like && cfg_pc) |=> (!o_zero_volt_charge_switch && o_overdischarge_switch))
    else $error("precharge overdischarge switch wrong");
  fix_dsg_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // [RULE8]
    (st_fail && i_fixed_pack_option && i_fail_charge_side) |=> o_discharge_switch)
    else $error("fixed pack discharge switch off");
  fix_chg_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // [RULE8]
    (st_fail && i_fixed_pack_option && !i_fail_charge_side) |=> o_charge_switch)
    else $error("fixed pack charge switch off");
  cc_nominal_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // [RULE7]
    !(st_chg && i_min_cell_below_pc) |=> o_requested_charge_current == $past(i_charge_current_nominal))
    else $error("charge current not nominal");

  // alarm path: compare result seen, then request raised a cycle later
  sequence alarm_armed_s;
    upd_d && (next_flags != 16'h0000) && (!alarm_pending || i_alarm_done);
  endsequence
  sequence alarm_raised_s;
    o_alarm_broadcast && (o_alarm_word != 16'h0000);
  endsequence
  sequence alarm_waiting_s;
    o_alarm_broadcast && !i_alarm_done;
  endsequence
  alarm_req_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // [RULE21]
    alarm_armed_s |=> alarm_raised_s)
    else $error("alarm request not raised");
  alarm_hold_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // [RULE20]
    alarm_waiting_s |=> o_alarm_broadcast)
    else $error("alarm request dropped before done");
  alarm_word_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // [RULE20]
    o_alarm_broadcast |-> o_alarm_word != 16'h0000)
    else $error("alarm request with empty word");

endmodule
`default_nettype wire

// ### tb/host_side_model.sv
// configuration memory and alarm bus master facing the block
`default_nettype none
module host_side_model #(
  parameter int DLY = 3
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [8:0] i_cfg_addr,
  output logic [7:0]      o_cfg_data,
  input  wire logic       i_alarm_broadcast,
  output logic            o_alarm_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // unloaded addresses give the inverted low address byte so stray reads show up
  always_comb begin
    case (i_cfg_addr)
      9'h000:  o_cfg_data = 8'h34;
      9'h001:  o_cfg_data = 8'h12;
      9'h002:  o_cfg_data = 8'h78;
      9'h003:  o_cfg_data = 8'h56;
      9'h115:  o_cfg_data = 8'h00;
      9'h116:  o_cfg_data = 8'h10;
      default: o_cfg_data = ~i_cfg_addr[7:0];
    endcase
  end
  // slow master: the write word takes DLY+1 cycles before it completes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 0;
      o_alarm_done <= 1'b0;
    end else begin
      o_alarm_done <= 1'b0;
      if (i_alarm_broadcast && !o_alarm_done) begin
        if (cnt == DLY) begin
          o_alarm_done <= 1'b1;
          cnt <= 0;
        end else begin
          cnt <= cnt + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the battery state and alarm block
`default_nettype none
`include "battery_state_alarm_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, wr_s, rd_s, dac, fix, fcs, mc, unit, cupd, rupd;
  logic        done, idone, chg, dsg, zv, od, bc;
  logic [7:0]  code, cfg_data;
  logic [8:0]  cfg_addr;
  logic [3:0]  st;
  logic [1:0]  cfg, sws, fc;
  logic [15:0] wdata, rdata, dcur, cap, rt, rdo, req, word, nom;
  int          error_cnt, n_compared;
  wire logic [3:0] sw4 = {chg, dsg, zv, od};

  battery_state_alarm_regs DUT (
    .I_REF_CLK(clk), .I_RST(rst), .i_cmd_wr(wr_s), .i_cmd_rd(rd_s), .i_cmd_code(code),
    .i_cmd_wdata(wdata), .o_cmd_rdata(rdo), .o_cfg_addr(cfg_addr), .i_cfg_data(cfg_data),
    .o_init_done(idone), .i_state_code(st), .i_depleted_ac(dac), .i_switch_configuration(cfg),
    .i_fixed_pack_option(fix), .i_capacity_unit_mode(unit), .i_switch_status(sws),
    .i_fail_cause(fc), .i_fail_charge_side(fcs), .i_discharge_current(dcur),
    .i_min_cell_below_pc(mc), .i_charge_current_nominal(nom), .i_capacity_left(cap),
    .i_capacity_update(cupd), .i_mean_runtime_left(rt), .i_runtime_update(rupd),
    .o_charge_switch(chg), .o_discharge_switch(dsg), .o_zero_volt_charge_switch(zv),
    .o_overdischarge_switch(od), .o_requested_charge_current(req), .o_alarm_broadcast(bc),
    .o_alarm_word(word), .i_alarm_done(done));

  host_side_model #(.DLY(3)) far (.i_clk(clk), .i_rst(rst), .i_cfg_addr(cfg_addr),
    .o_cfg_data(cfg_data), .i_alarm_broadcast(bc), .o_alarm_done(done));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop;
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] c);
    @(posedge clk);
    rd_s <= 1'b1;
    code <= c;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 rdata = rdo;
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    code <= c;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic t_regs;
    @(posedge clk);
    unit <= 1'b1;
    wr(`CMD_LOW_CAPACITY, 16'hFFFF);
    wr(`CMD_LOW_RUNTIME, 16'h0000);
    rd(`CMD_LOW_CAPACITY);
    cmp(rdata, 16'hFFFF);
    rd(`CMD_LOW_RUNTIME);
    cmp(rdata, 16'h0000);
    wr(`CMD_LOW_RUNTIME, 16'hFFFF);
    wr(8'h05, 16'h1111);
    rd(8'h05);
    cmp(rdata, 16'h0000);
    rd(`CMD_LOW_RUNTIME);
    cmp(rdata, 16'hFFFF);
  endtask

  task automatic t_status;
    logic [3:0] codes [13] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF};
    for (int i = 0; i < 13; i++) begin
      @(posedge clk);
      st <= codes[i];
      sws <= 2'h2;
      fc <= 2'h1;
      rd(`CMD_MAKER_PORT);
      cmp(rdata, {2'h2, 2'h1, codes[i], `STATUS_LOW_BYTE});
    end
  endtask

  task automatic sw(input logic [3:0] s, input logic [1:0] c, input logic a, input logic f,
                    input logic g, input logic m, input logic [15:0] d);
    @(posedge clk);
    st <= s;
    cfg <= c;
    dac <= a;
    fix <= f;
    fcs <= g;
    mc <= m;
    dcur <= d;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [3:0] m, input logic [3:0] e);
    cmp({12'h000, sw4 & m}, {12'h000, e});
  endtask

  task automatic t_switch;
    sw(4'h0, 2'h1, 0, 0, 0, 0, 16'h0000); chk(4'h8, 4'h8);
    sw(4'h0, 2'h0, 0, 0, 0, 0, 16'h0000); chk(4'h3, 4'h2);
    sw(4'h0, 2'h2, 0, 0, 0, 0, 16'h0000); chk(4'h3, 4'h2);
    sw(4'h3, 2'h0, 0, 0, 0, 0, 16'h0000); chk(4'h3, 4'h2);
    sw(4'h3, 2'h2, 0, 0, 0, 0, 16'h0000); chk(4'h3, 4'h1);
    sw(4'h1, 2'h2, 1, 0, 0, 0, 16'h0000); chk(4'h3, 4'h1);
    sw(4'hD, 2'h0, 0, 0, 0, 0, 16'h1001); chk(4'h8, 4'h8);
    sw(4'hD, 2'h0, 0, 0, 0, 0, 16'h1000); chk(4'h8, 4'h0);
    sw(4'hA, 2'h0, 0, 1, 1, 0, 16'h0000); chk(4'h4, 4'h4);
    sw(4'hA, 2'h0, 0, 0, 1, 0, 16'h0000); chk(4'h4, 4'h0);
    sw(4'hC, 2'h0, 0, 1, 0, 0, 16'h0000); chk(4'h8, 4'h8);
    sw(4'h5, 2'h0, 0, 0, 0, 1, 16'h0000); cmp(req, 16'h0000);
    nom <= 16'h0321;
    sw(4'h5, 2'h0, 0, 0, 0, 0, 16'h0000); cmp(req, 16'h0321);
  endtask

  task automatic upd(input logic r, input logic [15:0] v);
    @(posedge clk);
    if (r) begin
      rt <= v;
      rupd <= 1'b1;
    end else begin
      cap <= v;
      cupd <= 1'b1;
    end
    @(posedge clk);
    rupd <= 1'b0;
    cupd <= 1'b0;
  endtask

  // a request that never clears within 20 cycles fails the check and stops the run
  task automatic alm(input logic e, input logic [15:0] w);
    logic seen;
    int i;
    seen = 1'b0;
    for (i = 0; i < 12 && !seen; i++) begin
      @(posedge clk);
      #1 seen = (bc === 1'b1);
    end
    cmp({15'h0000, seen}, {15'h0000, e});
    if (seen) begin
      cmp(word, w);
      for (i = 0; i < 20 && bc !== 1'b0; i++) begin
        @(posedge clk);
        #1;
      end
      if (bc !== 1'b0) begin
        cmp({15'h0000, bc}, 16'h0000);
        report_and_stop;
      end
    end
  endtask

  task automatic t_alarm;
    wr(`CMD_LOW_CAPACITY, 16'h0100);
    upd(0, 16'h00FF); alm(1, `ALARM_FLAG_CAPACITY);
    upd(0, 16'h00FF); alm(1, `ALARM_FLAG_CAPACITY);
    upd(0, 16'h0100); alm(0, 16'h0000);
    wr(`CMD_LOW_CAPACITY, 16'h0000);
    upd(0, 16'h0000); alm(0, 16'h0000);
    wr(`CMD_LOW_RUNTIME, 16'h0010);
    upd(1, 16'h000F); alm(1, `ALARM_FLAG_RUNTIME);
    wr(`CMD_LOW_RUNTIME, 16'h0000);
    upd(1, 16'h0000); alm(0, 16'h0000);
    rd(`CMD_LOW_RUNTIME);
    cmp(rdata, 16'h0000);
  endtask

  // a second reset must reload both thresholds over host-written values
  task automatic t_reset;
    wr(`CMD_LOW_CAPACITY, 16'h1111);
    wr(`CMD_LOW_RUNTIME, 16'h2222);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    cmp({15'h0000, idone}, 16'h0000);
    @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 20 && idone !== 1'b1; i++) @(posedge clk);
    cmp({15'h0000, idone}, 16'h0001);
    rd(`CMD_LOW_CAPACITY);
    cmp(rdata, 16'h5678);
    rd(`CMD_LOW_RUNTIME);
    cmp(rdata, 16'h1234);
  endtask

  initial begin
    {wr_s, rd_s, dac, fix, fcs, mc, unit, cupd, rupd} = '0;
    {code, st, cfg, sws, fc, wdata, dcur} = '0;
    cap = 16'hFFFF;
    rt = 16'hFFFF;
    nom = 16'h0400;
    error_cnt = 0;
    n_compared = 0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 20 && idone !== 1'b1; i++) @(posedge clk);
    if (idone !== 1'b1) begin
      cmp({15'h0000, idone}, 16'h0001);
      report_and_stop;
    end
    rd(`CMD_LOW_CAPACITY);
    cmp(rdata, 16'h5678);
    rd(`CMD_LOW_RUNTIME);
    cmp(rdata, 16'h1234);
    t_regs;
    t_status;
    t_switch;
    t_alarm;
    t_reset;
    report_and_stop;
  end
endmodule
`default_nettype wire
